// [design/slc_pkg.sv]
// shared constants and types for the serializer pin and configuration control
package slc_pkg;
    // =========================================================
    // widths and counts
    localparam int DATA_W       = 24;
    localparam int CTRL_W       = 3;
    localparam int FILT_MIN     = 3;
    localparam int FILT_CNT_W   = 2;
    localparam int ADDR_W       = 7;
    localparam int REG_ADDR_W   = 8;
    // =========================================================
    // two-wire target defaults and register map
    localparam logic [6:0] TARGET_ADDR_DEF = 7'h1a;
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_STATUS      = 8'h01;
    // control register fields
    localparam int CTL_EDGE_OV   = 0;
    localparam int CTL_EDGE_VAL  = 1;
    localparam int CTL_SWING_OV  = 2;
    localparam int CTL_SWING_VAL = 3;
    localparam int CTL_EQ_OV     = 4;
    localparam int CTL_EQ_VAL    = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // =========================================================
    typedef enum logic [1:0] {
        SLC_FILT_OFF,
        SLC_FILT_ON,
        SLC_LEGACY_A,
        SLC_LEGACY_B
    } slc_mode_t;
    typedef enum {
        SLC_T_IDLE,
        SLC_T_ADDR,
        SLC_T_AACK,
        SLC_T_DATA,
        SLC_T_DACK,
        SLC_T_RD,
        SLC_T_RACK
    } slc_tstate_t;
endpackage : slc_pkg

// [design/slc_filt_if.sv]
// carrier between the top and the control-signal filter
`timescale 1ns/100ps
`default_nettype none
interface slc_filt_if;
    logic enable;
    logic raw;
    logic clean;
    modport top (output enable, output raw, input clean);
    modport filt (input enable, input raw, output clean);
endinterface : slc_filt_if
`default_nettype wire

// [design/slc_ctrl_filter.sv]
// glitch filter for one control input
`timescale 1ns/100ps
`default_nettype none
module slc_ctrl_filter
    import slc_pkg::*;
(
    input  wire logic clk_i,    // clock
    input  wire logic resetn_i, // sync reset, low
    slc_filt_if.filt  f         // filter carrier
);
    import slc_pkg::*;
    logic                  held;
    logic [FILT_CNT_W-1:0] cnt;
    logic                  next_held;
    logic [FILT_CNT_W-1:0] next_cnt;

    always_comb begin
        next_held = held;
        next_cnt  = '0;
        if (!f.enable) begin
            next_held = f.raw;
        end else if (f.raw != held) begin
            // a new level passes only after it stood for the full count
            if (cnt == FILT_CNT_W'(FILT_MIN - 1)) begin
                next_held = f.raw;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            held <= 1'b0;
            cnt  <= '0;
        end else begin
            held <= next_held;
            cnt  <= next_cnt;
        end
    end
    assign f.clean = held;

    // a filtered change must follow three enabled samples of the new level
    chk_filter_short: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(held) && $past(f.enable) && $past(f.enable, 2) && $past(f.enable, 3)
        |-> $past(f.raw) == held && $past(f.raw, 2) == held && $past(f.raw, 3) == held)
        else $error("filtered level changed too early");
endmodule : slc_ctrl_filter
`default_nettype wire

// [design/slc_pin_ctrl.sv]
// serializer pin-level control, configuration and two-wire target
`timescale 1ns/100ps
`default_nettype none
// =========================================================
// Summary of operation
// - power-down input high runs the serializer normally.
// - power-down low drives serial lines high, stops pll, resets control registers.
// - edge select 1 captures inputs on rising edge, 0 on falling edge.
// - swing select 1 gives large swing, 0 small low power; equalization is set separately.
// - swing selection may also come from a bus register.
// - edge selection and equalization may also come from bus registers.
// - equalization off when pin floats; on by grounded resistor or register.
// - configuration 00 disables control filter, 01 enables it.
// - configuration 10 and 11 select two distinct legacy link formats.
// - self-test enable 0 is normal mode, 1 is built-in self-test.
// - an optional two-wire target with clock input and open-drain data line.
module slc_pin_ctrl
    import slc_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEF // arbitrary base address
) (
    input  wire logic              clk_i,          // parallel clock input
    input  wire logic              resetn_i,       // sync reset, low
    input  wire logic              powerdown_n_i,  // power-down pin, low = down
    input  wire logic              strobe_edge_select_i, // edge pin
    input  wire logic              output_swing_select_i, // swing pin
    input  wire logic              eq_resistor_i,  // equalization resistor sensed
    input  wire logic [1:0]        config_i,       // mode pins
    input  wire logic              self_test_enable_i, // self-test pin
    input  wire logic [1:0]        target_address_select_i, // address offset
    input  wire logic [DATA_W-1:0] data_rise_i,    // data sampled on rising edge
    input  wire logic [DATA_W-1:0] data_fall_i,    // data sampled on falling edge
    input  wire logic [CTRL_W-1:0] ctrl_rise_i,    // control sampled on rising edge
    input  wire logic [CTRL_W-1:0] ctrl_fall_i,    // control sampled on falling edge
    input  wire logic              scl_i,          // bus clock, sampled
    input  wire logic              sda_i,          // bus data in
    output logic                   sda_o,          // bus data out, always 0
    output logic                   sda_oe_o,       // bus data drive enable
    output logic [DATA_W-1:0]      data_o,         // captured data
    output logic [CTRL_W-1:0]      ctrl_o,         // captured control, bits 0-1 filtered in configuration 01
    output logic                   serial_p_o,     // serial line high in power-down
    output logic                   serial_n_o,     // serial line high in power-down
    output logic                   pll_enable_o,   // pll run
    output logic                   tx_active_o,    // serializing
    output logic                   swing_high_o,   // large swing selected
    output logic                   eq_enable_o,    // equalization on
    output logic                   edge_rising_o,  // capture edge in use
    output logic                   self_test_o,    // self-test mode
    output slc_mode_t              link_mode_o     // filter / legacy format
);
    import slc_pkg::*;
    // =========================================================
    // state
    logic              run;
    logic [7:0]        ctrl_reg;
    logic [DATA_W-1:0] data_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic              next_run;
    logic [7:0]        next_ctrl_reg;
    logic [DATA_W-1:0] next_data_q;
    logic [CTRL_W-1:0] next_ctrl_q;
    logic              edge_sel;
    logic              filt_on;
    logic              rst_all;
    assign rst_all = !resetn_i || !powerdown_n_i;

    always_comb begin
        next_run = powerdown_n_i;
        edge_sel = ctrl_reg[CTL_EDGE_OV] ? ctrl_reg[CTL_EDGE_VAL] : strobe_edge_select_i;
        next_data_q = edge_sel ? data_rise_i : data_fall_i;
        next_ctrl_q = edge_sel ? ctrl_rise_i : ctrl_fall_i;
    end

    // =========================================================
    // two-wire target, single control register behind a subaddress
    logic        scl_q;
    logic        sda_q;
    slc_tstate_t ts;
    slc_tstate_t next_ts;
    logic [7:0]  sh;
    logic [7:0]  next_sh;
    logic [3:0]  bits;
    logic [3:0]  next_bits;
    logic        rw;
    logic        next_rw;
    logic [1:0]  bytes;
    logic [1:0]  next_bytes;
    logic [7:0]  sub;
    logic [7:0]  next_sub;
    logic        oe;
    logic        next_oe;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic [6:0]  my_addr;
    logic [7:0]  rd_val;
    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start_c  = scl_i && scl_q && sda_q && !sda_i;
    assign stop_c   = scl_i && scl_q && !sda_q && sda_i;
    assign my_addr  = TARGET_ADDR + {5'h00, target_address_select_i};
    assign rd_val   = (sub == REG_CTRL) ? ctrl_reg : {2'h0, link_mode_o, self_test_o,
                      eq_enable_o, swing_high_o, edge_sel};

    always_comb begin
        next_ts = ts;
        next_sh = sh;
        next_bits = bits;
        next_rw = rw;
        next_bytes = bytes;
        next_sub = sub;
        next_oe = oe;
        next_ctrl_reg = ctrl_reg;
        if (start_c) begin
            next_ts = SLC_T_ADDR;
            next_bits = 4'h0;
            next_oe = 1'b0;
        end else if (stop_c) begin
            next_ts = SLC_T_IDLE;
            next_oe = 1'b0;
        end else begin
            unique case (ts)
                SLC_T_IDLE: begin
                end
                SLC_T_ADDR, SLC_T_DATA: begin
                    if (scl_rise) begin
                        next_sh = {sh[6:0], sda_i};
                        next_bits = bits + 1'b1;
                    end else if (scl_fall && bits == 4'h8) begin
                        next_bits = 4'h0;
                        if (ts == SLC_T_ADDR) begin
                            next_rw = sh[0];
                            next_bytes = 2'h0;
                            next_oe = (sh[7:1] == my_addr);
                            next_ts = (sh[7:1] == my_addr) ? SLC_T_AACK : SLC_T_IDLE;
                        end else begin
                            next_oe = 1'b1;
                            next_ts = SLC_T_DACK;
                            if (bytes == 2'h0) begin
                                next_sub = sh;
                            end else if (sub == REG_CTRL) begin
                                next_ctrl_reg = sh;
                            end
                            next_bytes = 2'h1;
                        end
                    end
                end
                SLC_T_AACK, SLC_T_DACK: begin
                    if (scl_fall) begin
                        next_ts = rw ? SLC_T_RD : SLC_T_DATA;
                        next_sh = rd_val;
                        next_oe = rw && !rd_val[7];
                    end
                end
                SLC_T_RD: begin
                    if (scl_fall) begin
                        next_bits = bits + 1'b1;
                        next_sh = {sh[6:0], 1'b0};
                        next_oe = (bits != 4'h7) && !sh[6];
                        if (bits == 4'h7) begin
                            next_ts = SLC_T_RACK;
                            next_bits = 4'h0;
                        end
                    end
                end
                SLC_T_RACK: begin
                    if (scl_rise) begin
                        next_ts = sda_i ? SLC_T_IDLE : SLC_T_AACK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            run      <= 1'b0;
            ctrl_reg <= CTRL_RST;
            data_q   <= '0;
            ctrl_q   <= '0;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            ts       <= SLC_T_IDLE;
            sh       <= 8'h00;
            bits     <= 4'h0;
            rw       <= 1'b0;
            bytes    <= 2'h0;
            sub      <= 8'h00;
            oe       <= 1'b0;
        end else begin
            run      <= next_run;
            ctrl_reg <= next_ctrl_reg;
            data_q   <= next_data_q;
            ctrl_q   <= next_ctrl_q;
            scl_q    <= scl_i;
            sda_q    <= sda_i;
            ts       <= next_ts;
            sh       <= next_sh;
            bits     <= next_bits;
            rw       <= next_rw;
            bytes    <= next_bytes;
            sub      <= next_sub;
            oe       <= next_oe;
        end
    end

    // =========================================================
    // control-signal filter on data-enable and hsync
    assign filt_on = (config_i == 2'h1);
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            slc_filt_if fc ();
            assign fc.enable = filt_on;
            assign fc.raw    = ctrl_q[gi];
            slc_ctrl_filter u_filt (
                .clk_i    (clk_i),
                .resetn_i (!rst_all),
                .f        (fc)
            );
            assign ctrl_o[gi] = fc.clean;
        end
    endgenerate
    assign ctrl_o[2] = ctrl_q[2];

    // =========================================================
    // outputs
    assign data_o        = data_q;
    assign sda_o         = 1'b0;
    assign sda_oe_o      = oe;
    assign tx_active_o   = run && powerdown_n_i;
    assign pll_enable_o  = run && powerdown_n_i;
    assign serial_p_o    = 1'b1;
    assign serial_n_o    = !(run && powerdown_n_i);
    assign edge_rising_o = edge_sel;
    assign swing_high_o  = ctrl_reg[CTL_SWING_OV] ? ctrl_reg[CTL_SWING_VAL]
                                                  : output_swing_select_i;
    assign eq_enable_o   = ctrl_reg[CTL_EQ_OV] ? ctrl_reg[CTL_EQ_VAL] : eq_resistor_i;
    assign self_test_o   = self_test_enable_i;
    assign link_mode_o   = slc_mode_t'(config_i);

    // =========================================================
    chk_pd_lines: assert property (@(posedge clk_i) !powerdown_n_i |->
        serial_p_o && serial_n_o && !pll_enable_o)
        else $error("power-down lines wrong");
    chk_pd_regs: assert property (@(posedge clk_i) !powerdown_n_i |=> ctrl_reg == CTRL_RST)
        else $error("control registers not reset");
    chk_run_on: assert property (@(posedge clk_i) disable iff (!resetn_i)
        powerdown_n_i ##1 powerdown_n_i |-> tx_active_o)
        else $error("not running");
    chk_edge_cap: assert property (@(posedge clk_i) disable iff (rst_all)
        ##1 $past(edge_sel) |-> data_q == $past(data_rise_i))
        else $error("wrong capture edge");
    chk_swing_pin: assert property (@(posedge clk_i) disable iff (rst_all)
        !ctrl_reg[CTL_SWING_OV] |-> swing_high_o == output_swing_select_i)
        else $error("swing ignores pin");
    chk_eq_float: assert property (@(posedge clk_i) disable iff (rst_all)
        !eq_resistor_i && !ctrl_reg[CTL_EQ_OV] |-> !eq_enable_o)
        else $error("equalization on while floating");
    chk_mode_map: assert property (@(posedge clk_i) disable iff (rst_all)
        config_i == 2'h3 |-> link_mode_o == SLC_LEGACY_B)
        else $error("mode map wrong");
    chk_selftest: assert property (@(posedge clk_i) self_test_o == self_test_enable_i)
        else $error("self-test mismatch");
    chk_filter_off: assert property (@(posedge clk_i) disable iff (rst_all)
        config_i == 2'h0 ##1 config_i == 2'h0 |-> ctrl_o[0] == $past(ctrl_q[0]))
        else $error("filter not bypassed");
    cov_write: cover property (@(posedge clk_i) next_ctrl_reg != ctrl_reg);
    cov_read: cover property (@(posedge clk_i) ts == SLC_T_RD);
    cov_filt: cover property (@(posedge clk_i) filt_on && ctrl_o[0] != ctrl_q[0]);
endmodule : slc_pin_ctrl
`default_nettype wire

// [tb/slc_host_model.sv]
// two-wire bus master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module slc_host_model (
    input  wire logic clk_i,     // parallel clock input
    input  wire logic sda_i,     // resolved data line
    output var logic  scl_o,     // bus clock
    output var logic  sda_low_o  // pulls data line low
);
    // =========================================================
    // clocks per bus phase; the bench raises it for a slow master
    int half = 3;
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // one bit: data set while clock low, line sampled at end of high phase
    task automatic put_bit(input logic b, output logic got);
        sda_low_o = ~b;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        got   = sda_i;
        scl_o = 1'b0;
        tick(1);
    endtask : put_bit
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(v[i], g);
        put_bit(1'b1, g);
        ack = ~g;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
        put_bit(1'b1, g); // nack ends the read
    endtask : get_byte
    task automatic start_c();
        sda_low_o = 1'b0;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        sda_low_o = 1'b1;
        tick(half);
        scl_o = 1'b0;
        tick(1);
    endtask : start_c
    task automatic stop_c();
        sda_low_o = 1'b1;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        sda_low_o = 1'b0;
        tick(half);
    endtask : stop_c
    task automatic bus_write(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
                             output logic ack);
        logic a0, a1, a2;
        start_c();
        put_byte({a, 1'b0}, a0);
        put_byte(sub, a1);
        put_byte(d, a2);
        stop_c();
        ack = a0 & a1 & a2;
    endtask : bus_write
    task automatic bus_read(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d,
                            output logic ack);
        logic a0, a1, a2;
        start_c();
        put_byte({a, 1'b0}, a0);
        put_byte(sub, a1);
        stop_c();
        start_c();
        put_byte({a, 1'b1}, a2);
        get_byte(d);
        stop_c();
        ack = a0 & a1 & a2;
    endtask : bus_read
endmodule : slc_host_model
`default_nettype wire

// [tb/serializer_pin_config_control_tb_top.sv]
// self-checking bench for the serializer pin and configuration control
`timescale 1ns/100ps
`default_nettype none
module serializer_pin_config_control_tb_top;
    import slc_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, powerdown_n_i = 1'b1;
    logic edge_i = 1'b1, swing_i = 1'b0, eq_i = 1'b0, st_i = 1'b0;
    logic [1:0] config_i = 2'h0, asel_i = 2'h1;
    logic [DATA_W-1:0] d_rise = '0, d_fall = '0, data_o;
    logic [CTRL_W-1:0] c_rise = '0, c_fall = '0, ctrl_o;
    logic scl, sda_low, sda_o, sda_oe_o, sda_line, ser_p, ser_n, pll_o, act_o;
    logic swing_o, eq_o, edge_o, st_o;
    slc_mode_t mode_o;
    int n_mismatch = 0, num_checks = 0;
    logic [31:0] seed = 32'h56; // xorshift starts at 86
    always #10 clk_i = ~clk_i;
    assign sda_line = ~(sda_low | (sda_oe_o & ~sda_o)); // pulled up when released
    slc_pin_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .powerdown_n_i(powerdown_n_i),
        .strobe_edge_select_i(edge_i), .output_swing_select_i(swing_i), .eq_resistor_i(eq_i),
        .config_i(config_i), .self_test_enable_i(st_i), .target_address_select_i(asel_i),
        .data_rise_i(d_rise), .data_fall_i(d_fall), .ctrl_rise_i(c_rise), .ctrl_fall_i(c_fall),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .data_o(data_o),
        .ctrl_o(ctrl_o), .serial_p_o(ser_p), .serial_n_o(ser_n), .pll_enable_o(pll_o),
        .tx_active_o(act_o), .swing_high_o(swing_o), .eq_enable_o(eq_o),
        .edge_rising_o(edge_o), .self_test_o(st_o), .link_mode_o(mode_o));
    slc_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    // =========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [DATA_W-1:0] f_data(input logic e, input logic [DATA_W-1:0] r,
                                                 input logic [DATA_W-1:0] f);
        return e ? r : f;
    endfunction : f_data
    function automatic logic [7:0] f_status(input logic [1:0] m, input logic s, input logic q,
                                            input logic w, input logic e);
        return {2'b00, m, s, q, w, e};
    endfunction : f_status
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s t=%0t got=%h exp=%h", what, $time, got, exp);
        end
    endtask : chk
    // pulse on data-enable and hsync, then a quiet span of 138 clocks
    task automatic ctl_pulse(input int len, output logic seen);
        seen   = 1'b0;
        c_rise = 3'h3;
        c_fall = 3'h3;
        repeat (len) begin step(); seen = seen | (ctrl_o[0] & ctrl_o[1]); end
        c_rise = 3'h0;
        c_fall = 3'h0;
        repeat (8) begin step(); seen = seen | (ctrl_o[0] & ctrl_o[1]); end
        step(130);
    endtask : ctl_pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    // =========================================================
    // main sequence
    initial begin
        logic [31:0] r1, r2, r3;
        logic [6:0] addr;
        logic [7:0] rd;
        logic ack, seen;
        addr = TARGET_ADDR_DEF + {5'h0, asel_i};
        step(5);
        resetn_i = 1'b1;
        step(2);
        chk("run", {act_o, pll_o}, 32'h3);
        $display("test power-up done");
        for (int i = 0; i < 150; i++) begin
            r1 = rnd();
            r2 = rnd();
            r3 = rnd();
            d_rise = r1[DATA_W-1:0];
            d_fall = r2[DATA_W-1:0];
            edge_i = r3[0];
            swing_i = r3[1];
            eq_i = r3[2];
            st_i = r3[3];
            config_i = (i < 4) ? i[1:0] : r3[5:4];
            step();
            chk("data", data_o, f_data(r3[0], r1[DATA_W-1:0], r2[DATA_W-1:0]));
            chk("edge", edge_o, r3[0]);
            chk("swing", swing_o, r3[1]);
            chk("eq", eq_o, r3[2]);
            chk("selftest", st_o, r3[3]);
            chk("mode", mode_o, config_i);
        end
        $display("test pins done");
        {edge_i, swing_i, eq_i, st_i} = 4'h8;
        config_i = 2'h1;
        ctl_pulse(2, seen);
        chk("short pulse", seen, 1'b0);
        ctl_pulse(3, seen);
        chk("long pulse", seen, 1'b1);
        config_i = 2'h0;
        ctl_pulse(1, seen);
        chk("unfiltered", seen, 1'b1);
        c_rise = 3'h4;
        step();
        chk("vsync", ctrl_o[2], 1'b1);
        c_rise = 3'h0;
        step(130);
        $display("test filter done");
        host.bus_write(addr ^ 7'h40, REG_CTRL, 8'h0c, ack);
        chk("foreign ack", ack, 1'b0);
        chk("foreign swing", swing_o, 1'b0);
        host.bus_write(addr, REG_CTRL, 8'h0c, ack);
        chk("ack", ack, 1'b1);
        chk("swing ovr", swing_o, 1'b1);
        host.bus_write(addr, REG_CTRL, 8'h31, ack);
        chk("edge ovr", {edge_o, eq_o, swing_o}, 32'h2);
        d_rise = 24'h5a5a5a;
        d_fall = 24'h0f0f0f;
        step();
        chk("ovr capture", data_o, 24'h0f0f0f);
        host.half = 8;
        config_i = 2'h2;
        host.bus_read(addr, REG_STATUS, rd, ack);
        chk("read ack", ack, 1'b1);
        chk("status", rd, f_status(2'h2, 1'b0, 1'b1, 1'b0, 1'b0));
        $display("test bus done");
        powerdown_n_i = 1'b0;
        step(2);
        chk("down", {ser_p, ser_n, pll_o, act_o}, 32'hc);
        powerdown_n_i = 1'b1;
        step(2);
        chk("pins again", {edge_o, eq_o, swing_o}, 32'h4);
        chk("run again", {act_o, pll_o}, 32'h3);
        $display("test power-down done");
        tally_and_finish();
    end
endmodule : serializer_pin_config_control_tb_top
`default_nettype wire
